// ### hdl/eipc_ctrl.sv
// External interrupt priority controller with AHB-Lite register slave
// How it works
// - NMI level bit mirrors pin, read only
// - Reserved control bits 14..9 read zero
// - NMI polarity: 0 falling, 1 rising edge
// - Sense bit: 0 low level, 1 falling edge
// - Level mode flag follows pin directly
// - Edge mode flag sets on falling edge
// - Edge flag clears by read-1 then write-0
// - Edge flag clears when exception processing runs
// - Status cleared by power-on, kept in standby
// - Highest programmed level among requests wins
// - Pending edges held; resets discard them
// - Ties resolved by fixed default order
// - Accept only if level exceeds core mask
// - Acceptance drives active-low output low
// - Accepted level loaded into core mask
// - Level/module requests release after mask load
// - Edge requests release at exception start
// - Higher accept while busy keeps output low
// - DMA judge 1, compare 2 or 3
// - DMA-selected sources masked from arbiter
// - DMA-routed sources never interrupt core
// - Four-bit fields, level 0 to 15
module eipc_ctrl
   import eipc_pkg::*;
#(
   parameter int NUM_MOD = 4            // on-chip module sources
) (
   // Clock and reset
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   input  wire logic                 manual_reset,
   // AHB-Lite slave
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic      [31:0]          hrdata,
   output logic                      hreadyout,
   output logic                      hresp,
   // Interrupt pins, active low except NMI
   input  wire logic                 nmi_pin,
   input  wire logic [7:0]           ext_req_pin_n,
   // On-chip module requests and DMA settings
   input  wire logic [NUM_MOD-1:0]   mod_req,
   input  wire eipc_dma_cfg_t        dma_cfg,
   // Core side
   input  wire logic [3:0]           cpu_mask_level,
   input  wire logic                 core_exc_start,
   input  wire logic                 core_mask_loaded,
   output logic                      accept_indicator_out_n,
   output eipc_accept_t              accept_info
);

   localparam int NSRC = EIPC_NUM_PINS + NUM_MOD;

   // Refuse sizes the priority register cannot hold
   if (NUM_MOD < 1 || NUM_MOD > 4) begin : g_chk
      $error("NUM_MOD must lie between 1 and 4");
   end

   // ---------------- Synchronisers (three stages, agreement filter)
   logic [8:0]  sync1_reg, sync2_reg, sync3_reg;   // pins, NMI at bit 8
   logic [8:0]  pin_flt_reg, pin_flt_next;         // filtered levels
   logic [8:0]  pin_old_reg;                       // for edge detection

   // Filtered level only changes when stages two and three agree
   always_comb begin
      pin_flt_next = pin_flt_reg;
      for (int i = 0; i < 9; i++) begin
         if (sync2_reg[i] == sync3_reg[i]) begin
            pin_flt_next[i] = sync3_reg[i];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_reg   <= 9'h1ff;                 // idle: pins high
         sync2_reg   <= 9'h1ff;
         sync3_reg   <= 9'h1ff;
         pin_flt_reg <= 9'h1ff;
         pin_old_reg <= 9'h1ff;
      end else begin
         sync1_reg   <= {nmi_pin, ext_req_pin_n};
         sync2_reg   <= sync1_reg;
         sync3_reg   <= sync2_reg;
         pin_flt_reg <= pin_flt_next;
         pin_old_reg <= pin_flt_reg;
      end
   end

   // ---------------- Register file state
   logic         nmi_edge_polarity_reg, nmi_edge_polarity_next;          // nmi_edge_polarity
   logic [7:0]   sense_reg, sense_next;        // per pin, index = pin
   logic [7:0]   flag_reg, flag_next;          // edge-held flags
   logic [7:0]   seen_reg, seen_next;          // flag read as one
   logic         nmi_pend_reg, nmi_pend_next;  // NMI edge pending
   logic [31:0]  prio_x_reg, prio_x_next;      // pin 0 at [31:28]
   logic [15:0]  prio_m_reg, prio_m_next;      // module 0 at [15:12]
   logic         dph_wr_reg;                   // write data phase
   logic [7:0]   dph_addr_reg;
   logic [31:0]  hrdata_next;
   logic [7:0]   flag_view;                    // flags as software sees
   logic [7:0]   rev_view;                     // pin 0 at bit 7
   logic [15:0]  psc_view;
   logic         addr_ok;                      // AHB address phase taken
   logic         nmi_edge;

   // Accept state, declared here since the status read shows it
   logic         acc_busy_reg, acc_busy_next;
   logic         acc_edge_reg, acc_edge_next;
   logic         acc_n_reg, acc_n_next;
   eipc_accept_t acc_reg, acc_next;

   assign addr_ok = hsel && htrans[1] && hready;

   // Software view of flags: level pins show the pin, edge pins the hold
   always_comb begin
      flag_view = 8'h00;
      rev_view  = 8'h00;
      for (int i = 0; i < 8; i++) begin
         flag_view[i] = sense_reg[i] ? flag_reg[i] : !pin_flt_reg[i];
         rev_view[7-i] = flag_view[i];
      end
      psc_view = 16'h0000;
      psc_view[EIPC_PSC_NMI_PIN_LEVEL_BIT] = pin_flt_reg[8];
      psc_view[EIPC_PSC_RSV_HI:EIPC_PSC_RSV_LO] = 6'h00;
      psc_view[EIPC_PSC_NMI_EDGE_POLARITY_BIT] = nmi_edge_polarity_reg;
      for (int i = 0; i < 8; i++) begin
         psc_view[7-i] = sense_reg[i];
      end
   end

   assign nmi_edge = nmi_edge_polarity_reg ? (pin_flt_reg[8] && !pin_old_reg[8])
                              : (!pin_flt_reg[8] && pin_old_reg[8]);

   // Next values of the register file and the held requests
   always_comb begin
      nmi_edge_polarity_next     = nmi_edge_polarity_reg;
      sense_next    = sense_reg;
      flag_next     = flag_reg;
      seen_next     = seen_reg;
      prio_x_next   = prio_x_reg;
      prio_m_next   = prio_m_reg;
      nmi_pend_next = nmi_pend_reg;
      hrdata_next   = 32'h0000_0000;      // unmapped reads give zero
      // Read data is fixed at the address phase, zero wait
      if (addr_ok && !hwrite) begin
         unique case (haddr[7:0])
            EIPC_OFS_PSC:    hrdata_next = {16'h0000, psc_view};
            EIPC_OFS_ERS: begin
               hrdata_next = {24'h000000, rev_view};
               seen_next = seen_reg | (flag_view & sense_reg);
            end
            EIPC_OFS_PRIO_X: hrdata_next = prio_x_reg;
            EIPC_OFS_PRIO_M: hrdata_next = {16'h0000, prio_m_reg};
            EIPC_OFS_STAT:   hrdata_next = {16'h0000, 3'h0, acc_busy_reg,
                                            1'b0, acc_reg.level,
                                            1'b0, acc_reg.src};
            default:         hrdata_next = 32'h0000_0000;
         endcase
      end
      // Write data phase
      if (dph_wr_reg) begin
         unique case (dph_addr_reg)
            EIPC_OFS_PSC: begin
               nmi_edge_polarity_next = hwdata[EIPC_PSC_NMI_EDGE_POLARITY_BIT];
               for (int i = 0; i < 8; i++) begin
                  sense_next[i] = hwdata[7-i];
               end
            end
            EIPC_OFS_ERS: begin
               for (int i = 0; i < 8; i++) begin
                  if (!hwdata[7-i] && seen_reg[i]) begin
                     flag_next[i] = 1'b0;
                  end
               end
               seen_next = 8'h00;
            end
            EIPC_OFS_PRIO_X: prio_x_next = hwdata;
            EIPC_OFS_PRIO_M: prio_m_next = hwdata[15:0];
            default: ;                     // writes elsewhere ignored
         endcase
      end
      for (int i = 0; i < 8; i++) begin
         if (core_exc_start && acc_busy_reg && acc_edge_reg &&
             acc_reg.src == 5'(i)) begin
            flag_next[i] = 1'b0;
         end
         // falling edge sets, wins over a clear
         if (sense_reg[i] && !pin_flt_reg[i] && pin_old_reg[i]) begin
            flag_next[i] = 1'b1;
         end
         // Level pins hold nothing
         if (!sense_next[i]) begin
            flag_next[i] = 1'b0;
         end
      end
      if (core_exc_start && acc_busy_reg && acc_reg.src == EIPC_NMI_SRC) begin
         nmi_pend_next = 1'b0;
      end
      if (nmi_edge) begin
         nmi_pend_next = 1'b1;
      end
      if (manual_reset) begin
         flag_next     = EIPC_FLAG_RST;
         seen_next     = 8'h00;
         nmi_pend_next = 1'b0;
      end
   end

   // power-on reset clears all; manual_reset clears only flags, seen marks and pending NMI; standby has no effect
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         nmi_edge_polarity_reg     <= EIPC_NMI_EDGE_POLARITY_RST;
         sense_reg    <= EIPC_SENSE_RST;
         flag_reg     <= EIPC_FLAG_RST;
         seen_reg     <= 8'h00;
         nmi_pend_reg <= 1'b0;
         prio_x_reg   <= EIPC_PRIO_RST;
         prio_m_reg   <= EIPC_PRIO_RST[15:0];
         dph_wr_reg   <= 1'b0;
         dph_addr_reg <= 8'h00;
         hrdata       <= 32'h0000_0000;
         hreadyout    <= 1'b0;
         hresp        <= 1'b0;
      end else begin
         nmi_edge_polarity_reg     <= nmi_edge_polarity_next;
         sense_reg    <= sense_next;
         flag_reg     <= flag_next;
         seen_reg     <= seen_next;
         nmi_pend_reg <= nmi_pend_next;
         prio_x_reg   <= prio_x_next;
         prio_m_reg   <= prio_m_next;
         dph_wr_reg   <= addr_ok && hwrite;
         dph_addr_reg <= haddr[7:0];
         hrdata       <= hrdata_next;
         hreadyout    <= 1'b1;          // never stretches a transfer
         hresp        <= 1'b0;          // always OKAY
      end
   end

   // ---------------- DMA judgment and arbitration pipeline
   logic [NSRC-1:0] raw_req, dma_mask;
   logic [NSRC-1:0] judged_reg;           // after DMA judgment
   logic [7:0]      pin_dly_reg;          // extra compare state for pins
   logic [NSRC-1:0] cand;
   logic            win_found;
   logic [4:0]      win_lvl, win_src;
   logic            win_v_reg;
   logic [4:0]      win_lvl_reg, win_src_reg;
   logic            nmi_dly_reg;
   logic [0:NSRC-1][3:0] src_lvl; // pin 0 first, then modules

   // Level field of every source, pins ahead of modules
   assign src_lvl = {prio_x_reg, prio_m_reg[15 -: 4*NUM_MOD]};

   // Raw requests and DMA routing mask per source
   always_comb begin
      raw_req = {mod_req, flag_view};
      dma_mask = '0;
      for (int i = 0; i < NSRC; i++) begin
         for (int c = 0; c < 4; c++) begin
            // master and channel enable with source match
            if (dma_cfg.master_en && dma_cfg.chan_en[c] &&
                dma_cfg.chan_src[c] == 5'(i)) begin
               dma_mask[i] = 1'b1;
            end
         end
      end
      // pins wait one more compare state
      cand = judged_reg;
      cand[7:0] = pin_dly_reg;
   end

   // Winner: highest level, lowest index on equal levels
   always_comb begin
      win_found = 1'b0;
      win_lvl   = 5'h00;
      win_src   = 5'h00;
      for (int i = 0; i < NSRC; i++) begin
         if (cand[i] && (!win_found || {1'b0, src_lvl[i]} > win_lvl)) begin
            win_found = 1'b1;
            win_lvl   = {1'b0, src_lvl[i]};
            win_src   = 5'(i);
         end
      end
      if (nmi_dly_reg) begin
         win_found = 1'b1;
         win_lvl   = EIPC_NMI_LVL;
         win_src   = EIPC_NMI_SRC;
      end
   end

   // Pipeline registers: judgment, pin delay, compare result
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         judged_reg  <= '0;
         pin_dly_reg <= 8'h00;
         nmi_dly_reg <= 1'b0;
         win_v_reg   <= 1'b0;
         win_lvl_reg <= 5'h00;
         win_src_reg <= 5'h00;
      end else begin
         // routed sources never reach the core
         judged_reg  <= raw_req & ~dma_mask;
         pin_dly_reg <= judged_reg[7:0];
         nmi_dly_reg <= nmi_pend_reg;
         win_v_reg   <= win_found;
         win_lvl_reg <= win_lvl;
         win_src_reg <= win_src;
      end
   end

   // ---------------- Acceptance and the active-low request output
   logic take;
   logic win_live;

   always_comb begin
      // Stale winner entries need a live request
      win_live = (win_src_reg == EIPC_NMI_SRC) && nmi_pend_reg;
      for (int i = 0; i < NSRC; i++) begin
         if (win_src_reg == 5'(i)) win_live = raw_req[i] && !dma_mask[i];
      end
      take = win_v_reg && (win_lvl_reg > {1'b0, cpu_mask_level}) &&
             (!acc_busy_reg || win_lvl_reg > acc_reg.level) && win_live;
      acc_busy_next = acc_busy_reg;
      acc_edge_next = acc_edge_reg;
      acc_n_next    = acc_n_reg;
      acc_next      = acc_reg;
      // edge source released at exception start
      if (acc_busy_reg && acc_edge_reg && core_exc_start) begin
         acc_busy_next = 1'b0;
         acc_n_next    = 1'b1;
      end
      // level or module released after mask load
      if (acc_busy_reg && !acc_edge_reg && core_mask_loaded) begin
         acc_busy_next = 1'b0;
         acc_n_next    = 1'b1;
      end
      // a higher accept overrides the release
      if (take) begin
         acc_busy_next = 1'b1;
         acc_n_next    = 1'b0;
         acc_next.level = win_lvl_reg;
         acc_next.src   = win_src_reg;
         acc_edge_next  = (win_src_reg == EIPC_NMI_SRC) ||
                          (win_src_reg < 5'd8 && sense_reg[win_src_reg[2:0]]);
      end
   end

   // Output flip-flops feed the core directly
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_busy_reg <= 1'b0;
         acc_edge_reg <= 1'b0;
         acc_n_reg    <= 1'b1;
         acc_reg      <= '0;
      end else begin
         acc_busy_reg <= acc_busy_next;
         acc_edge_reg <= acc_edge_next;
         acc_n_reg    <= acc_n_next;
         acc_reg      <= acc_next;
      end
   end

   assign accept_indicator_out_n = acc_n_reg;
   assign accept_info            = acc_reg;

endmodule // eipc_ctrl

// ### hdl/eipc_pkg.sv
// Shared constants and carriers for the external interrupt priority block
package eipc_pkg;

   // Register byte offsets on the AHB-Lite slave
   localparam logic [7:0] EIPC_OFS_PSC    = 8'h00; // pin_sense_control
   localparam logic [7:0] EIPC_OFS_ERS    = 8'h04; // ext_request_status
   localparam logic [7:0] EIPC_OFS_PRIO_X = 8'h08; // priority, pins 0..7
   localparam logic [7:0] EIPC_OFS_PRIO_M = 8'h0c; // priority, modules
   localparam logic [7:0] EIPC_OFS_STAT   = 8'h10; // acceptance status

   // Field positions inside pin_sense_control
   localparam int EIPC_PSC_NMI_PIN_LEVEL_BIT = 15;  // nmi_pin_level, read only
   localparam int EIPC_PSC_NMI_EDGE_POLARITY_BIT = 8;   // nmi_edge_polarity
   localparam int EIPC_PSC_RSV_HI   = 14;  // reserved, reads zero
   localparam int EIPC_PSC_RSV_LO   = 9;

   // Values after reset
   localparam logic       EIPC_NMI_EDGE_POLARITY_RST  = 1'b0;     // falling edge
   localparam logic [7:0] EIPC_SENSE_RST = 8'h00;    // low level
   localparam logic [7:0] EIPC_FLAG_RST  = 8'h00;
   localparam logic [31:0] EIPC_PRIO_RST = 32'h0000_0000;

   // Priority levels and source coding
   localparam int          EIPC_NUM_PINS = 8;
   localparam logic [4:0]  EIPC_NMI_LVL  = 5'h10;    // above any field
   localparam logic [4:0]  EIPC_NMI_SRC  = 5'h1f;    // source code of NMI
   localparam int          EIPC_SYNC_LEN = 3;

   // Pipeline lengths in clock cycles
   localparam int EIPC_DMA_JUDGE_CYC = 1;
   localparam int EIPC_CMP_MOD_CYC   = 2;
   localparam int EIPC_CMP_PIN_CYC   = 3;

   // DMA activation settings seen by the arbiter
   typedef struct packed {
      logic             master_en;   // dma_master_enable
      logic [3:0]       chan_en;     // dma_channel0..3_enable
      logic [3:0][4:0]  chan_src;    // activation source per channel
   } eipc_dma_cfg_t;

   // Accepted request handed to the core
   typedef struct packed {
      logic [4:0] level;             // 0..15, or 16 for NMI
      logic [4:0] src;               // 0..7 pins, 8.. modules, NMI code
   } eipc_accept_t;

endpackage : eipc_pkg

// ### sim/eipc_core_model.sv
// Behavioural processor core facing the acceptance output
module eipc_core_model
   import eipc_pkg::*;
(
   // Clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // Bench control: service on, idle mask, decode delay
   input  wire logic         run,
   input  wire logic [3:0]   tb_mask,
   input  wire logic [3:0]   dly,
   // Block side
   input  wire logic         accept_indicator_out_n,
   input  wire eipc_accept_t accept_info,
   output logic [3:0]        cpu_mask_level,
   output logic              core_exc_start,
   output logic              core_mask_loaded
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] cnt_reg;  // Cycles within a step
   logic [1:0] step_reg; // Idle, decode, save, settle
   logic [4:0] lvl_reg;  // Level taken at exception start

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_reg          <= 4'h0;
         step_reg         <= 2'd0;
         lvl_reg          <= 5'h0;
         cpu_mask_level   <= 4'h0;
         core_exc_start   <= 1'b0;
         core_mask_loaded <= 1'b0;
      end else begin
         core_exc_start   <= 1'b0;
         core_mask_loaded <= 1'b0;
         cnt_reg          <= cnt_reg + 4'h1;
         case (step_reg)
            2'd0: begin
               cnt_reg <= 4'h0;
               if (!run) cpu_mask_level <= tb_mask;
               else if (!accept_indicator_out_n) step_reg <= 2'd1;
            end
            2'd1: if (cnt_reg == dly) begin
               core_exc_start <= 1'b1;
               lvl_reg        <= accept_info.level;
               cnt_reg        <= 4'h0;
               step_reg       <= 2'd2;
            end
            2'd2: if (cnt_reg == 4'h3) begin
               // NMI level does not fit; top mask used
               cpu_mask_level   <= lvl_reg[4] ? 4'hf : lvl_reg[3:0];
               // Pulse only while the request still stands
               core_mask_loaded <= !accept_indicator_out_n;
               step_reg         <= 2'd3;
            end
            // Let the release land before looking again
            default: step_reg <= 2'd0;
         endcase
      end
   end
endmodule // eipc_core_model

// ### sim/eipc_ctrl_properties.sv
// Concurrent checks on the interrupt priority block ports
module eipc_ctrl_properties
   import eipc_pkg::*;
#(
   parameter int NUM_MOD = 4
) (
   // Clock and reset
   input wire logic               hclk,
   input wire logic               hresetn,
   // Register bus
   input wire logic               hsel,
   input wire logic [31:0]        haddr,
   input wire logic [1:0]         htrans,
   input wire logic               hwrite,
   input wire logic               hready,
   input wire logic [31:0]        hrdata,
   // Requests and core side
   input wire logic [NUM_MOD-1:0] mod_req,
   input wire eipc_dma_cfg_t      dma_cfg,
   input wire logic [3:0]         cpu_mask_level,
   input wire logic               core_exc_start,
   input wire logic               core_mask_loaded,
   input wire logic               accept_indicator_out_n,
   input wire eipc_accept_t       accept_info
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Read taken at one offset, then its data phase
   sequence s_rd(ofs);
      hsel && htrans[1] && hready && !hwrite && haddr[7:0] == ofs ##1 1'b1;
   endsequence
   // Acceptance output newly driven low
   sequence s_acc;
      $fell(accept_indicator_out_n);
   endsequence
   // Output low across two edges
   sequence s_held;
      !accept_indicator_out_n && !$past(accept_indicator_out_n);
   endsequence

   property p_psc_rsv;
      s_rd(EIPC_OFS_PSC) |-> hrdata[31:16] == 16'h0 && hrdata[14:9] == 6'h0;
   endproperty
   a_psc_rsv: assert property (p_psc_rsv)
      else $error("reserved control bits not zero");
   property p_above_mask;
      s_acc |-> accept_info.level > {1'b0, $past(cpu_mask_level)};
   endproperty
   a_above_mask: assert property (p_above_mask)
      else $error("accepted level not above mask");
   property p_level_nonzero;
      !accept_indicator_out_n |-> accept_info.level != 5'h0;
   endproperty
   a_level_nonzero: assert property (p_level_nonzero)
      else $error("level zero accepted");
   // Release only follows a core pulse
   property p_release;
      $rose(accept_indicator_out_n) |->
         $past(core_exc_start) || $past(core_mask_loaded);
   endproperty
   a_release: assert property (p_release)
      else $error("output released without core pulse");
   property p_no_drop;
      s_held |-> accept_info.level >= $past(accept_info.level);
   endproperty
   a_no_drop: assert property (p_no_drop)
      else $error("accepted level dropped while low");
   property p_same_src;
      s_held ##0 accept_info.level == $past(accept_info.level)
         |-> $stable(accept_info.src);
   endproperty
   a_same_src: assert property (p_same_src)
      else $error("source replaced at equal level");
   property p_mod_lat;
      s_acc ##0 accept_info.src inside {[5'd8:5'd11]}
         |-> $past(mod_req, 3) != '0;
   endproperty
   a_mod_lat: assert property (p_mod_lat)
      else $error("module accepted too early");
   property p_dma_mask;
      (dma_cfg.master_en && dma_cfg.chan_en[0]) [*6] ##0 s_acc
         |-> accept_info.src != dma_cfg.chan_src[0];
   endproperty
   a_dma_mask: assert property (p_dma_mask)
      else $error("DMA-routed source accepted");
   property p_nmi_level;
      s_acc ##0 accept_info.src == EIPC_NMI_SRC
         |-> accept_info.level == EIPC_NMI_LVL;
   endproperty
   a_nmi_level: assert property (p_nmi_level)
      else $error("NMI not at top level");
endmodule // eipc_ctrl_properties

// ### sim/ext_interrupt_priority_controller_tb.sv
// Self-checking bench for the interrupt priority block
module ext_interrupt_priority_controller_tb;
   import eipc_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic          hclk = 1'b0, hresetn = 1'b0, manual_reset = 1'b0;
   logic          hsel = 1'b0, hwrite = 1'b0, nmi_pin = 1'b1;
   logic          run = 1'b0;
   logic [31:0]   haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0]    htrans = 2'h0;
   logic [7:0]    pin_n = 8'hff;
   logic [3:0]    mod_req = 4'h0, tb_mask = 4'h0, dly = 4'h1, mask;
   eipc_dma_cfg_t dma_cfg = '0;
   eipc_accept_t  info;
   logic          hreadyout, hresp, exc, mload, out_n;
   int            num_errors = 0, num_checks = 0;

   always #2.5 hclk = ~hclk;

   eipc_ctrl #(.NUM_MOD(4)) uut (
      .hclk(hclk), .hresetn(hresetn), .manual_reset(manual_reset),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .nmi_pin(nmi_pin), .ext_req_pin_n(pin_n), .mod_req(mod_req),
      .dma_cfg(dma_cfg), .cpu_mask_level(mask), .core_exc_start(exc),
      .core_mask_loaded(mload), .accept_indicator_out_n(out_n),
      .accept_info(info));
   eipc_core_model core (
      .hclk(hclk), .hresetn(hresetn), .run(run), .tb_mask(tb_mask),
      .dly(dly), .accept_indicator_out_n(out_n), .accept_info(info),
      .cpu_mask_level(mask), .core_exc_start(exc),
      .core_mask_loaded(mload));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("Error %0t: got %h expected %h", $time, got, exp);
         num_errors++;
      end
   endtask
   // One single word transfer; waits for the slave, no fixed latency
   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr  <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      bus(1'b1, a, d, rd);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      bus(1'b0, a, 32'h0, rd);
      chk(rd, exp);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // Bounded wait for the acceptance output to reach a level
   task automatic wait_out(input logic val);
      int n;
      n = 0;
      while (out_n !== val && n < 40) begin
         @(posedge hclk);
         n++;
      end
      chk({31'h0, out_n}, {31'h0, val});
   endtask
   task automatic chk_acc(input logic [4:0] lvl, input logic [4:0] src);
      chk({22'h0, info}, {22'h0, lvl, src});
   endtask
   task automatic pulse0;
      pin_n[0] <= 1'b0;
      idle(6);
      pin_n[0] <= 1'b1;
      idle(6);
   endtask

   task automatic t_reset;
      rd_chk(EIPC_OFS_PSC, 32'h0000_8000);
      rd_chk(EIPC_OFS_ERS, 32'h0);
      rd_chk(EIPC_OFS_PRIO_X, 32'h0);
      rd_chk(8'h20, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      $display("t_reset done");
   endtask
   task automatic t_nmi;
      wr(EIPC_OFS_PSC, 32'h0000_01ff);
      rd_chk(EIPC_OFS_PSC, 32'h0000_81ff);
      nmi_pin <= 1'b0;
      idle(10);
      chk({31'h0, out_n}, 32'h1);
      rd_chk(EIPC_OFS_PSC, 32'h0000_01ff);
      nmi_pin <= 1'b1;
      wait_out(1'b0);
      chk_acc(EIPC_NMI_LVL, EIPC_NMI_SRC);
      run <= 1'b1;
      wait_out(1'b1);
      run <= 1'b0;
      wr(EIPC_OFS_PSC, 32'h0);
      $display("t_nmi done");
   endtask
   task automatic t_level;
      wr(EIPC_OFS_PRIO_X, 32'h5000_0000);
      tb_mask  <= 4'h5;
      pin_n[0] <= 1'b0;
      idle(10);
      rd_chk(EIPC_OFS_ERS, 32'h80);
      chk({31'h0, out_n}, 32'h1);
      tb_mask <= 4'h4;
      wait_out(1'b0);
      chk_acc(5'd5, 5'd0);
      dly <= 4'd6;
      run <= 1'b1;
      wait_out(1'b1);
      pin_n[0] <= 1'b1;
      idle(10);
      run      <= 1'b0;
      rd_chk(EIPC_OFS_ERS, 32'h0);
      $display("t_level done");
   endtask
   task automatic t_edge;
      wr(EIPC_OFS_PSC, 32'h80);
      tb_mask <= 4'hf;
      pulse0();
      rd_chk(EIPC_OFS_ERS, 32'h80);
      wr(EIPC_OFS_ERS, 32'h0);
      rd_chk(EIPC_OFS_ERS, 32'h0);
      pulse0();
      wr(EIPC_OFS_ERS, 32'h0);
      rd_chk(EIPC_OFS_ERS, 32'h80);
      manual_reset <= 1'b1;
      idle(1);
      manual_reset <= 1'b0;
      rd_chk(EIPC_OFS_ERS, 32'h0);
      tb_mask <= 4'h0;
      pulse0();
      dly     <= 4'd1;
      run     <= 1'b1;
      wait_out(1'b0);
      chk_acc(5'd5, 5'd0);
      wait_out(1'b1);
      run <= 1'b0;
      rd_chk(EIPC_OFS_ERS, 32'h0);
      $display("t_edge done");
   endtask
   task automatic t_arb;
      wr(EIPC_OFS_PSC, 32'h0);
      wr(EIPC_OFS_PRIO_X, 32'h0377_0000);
      pin_n[1] <= 1'b0;
      wait_out(1'b0);
      chk_acc(5'd3, 5'd1);
      pin_n[3:2] <= 2'b00;
      idle(10);
      chk({31'h0, out_n}, 32'h0);
      chk_acc(5'd7, 5'd2);
      pin_n <= 8'hff;
      run   <= 1'b1;
      wait_out(1'b1);
      run <= 1'b0;
      $display("t_arb done");
   endtask
   task automatic t_dma;
      wr(EIPC_OFS_PRIO_M, 32'h0000_6200);
      for (int i = 0; i < 3; i++) begin
         // Routed, master off, channel off in turn
         dma_cfg.master_en   <= (i != 1);
         dma_cfg.chan_en     <= {3'h0, i != 2};
         dma_cfg.chan_src[0] <= 5'd8;
         idle(8);
         mod_req[1:0] <= 2'b11;
         wait_out(1'b0);
         chk_acc(i == 0 ? 5'd2 : 5'd6, i == 0 ? 5'd9 : 5'd8);
         mod_req <= 4'h0;
         run     <= 1'b1;
         wait_out(1'b1);
         run <= 1'b0;
         idle(4);
      end
      $display("t_dma done");
   endtask

   task automatic print_verdict;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      idle(10);
      hresetn <= 1'b1;
      idle(2);
      t_reset();
      t_nmi();
      t_level();
      t_edge();
      t_arb();
      t_dma();
      print_verdict();
   end
   // Whole run needs well under a thousand cycles; cut a hang at 40000 cycles
   initial begin
      #200000;
      num_errors++;
      print_verdict();
   end
endmodule // ext_interrupt_priority_controller_tb

bind eipc_ctrl eipc_ctrl_properties #(.NUM_MOD(NUM_MOD)) u_props (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .mod_req(mod_req), .dma_cfg(dma_cfg), .cpu_mask_level(cpu_mask_level),
   .core_exc_start(core_exc_start), .core_mask_loaded(core_mask_loaded),
   .accept_indicator_out_n(accept_indicator_out_n),
   .accept_info(accept_info));
